//--- hw/asd_bridge.sv
// Address decoder and width-adapting bridge for the shared memory space
`timescale 1ns/1ps

// Contract
// - One shared address and data bus
// - Decode full 64 KB address space
// - Fetches even; data byte or word
// - Program memory ends at top; start parameter
// - Top sixteen words hold interrupt vectors
// - Program memory serves fetches and data reads
// - RAM base fixed, end parameter, code and data
// - Route 16-bit peripheral window
// - Byte read of 16-bit peripheral zero-extends
// - Route 8-bit peripheral window
// - Word write to 8-bit peripheral keeps low
// - Lowest sixteen bytes are byte registers
// - Words even; low byte at even address
module asd_bridge
    import asd_pkg::*;
#(
    parameter logic [15:0] RAM_HI  = ASD_RAM_HI_DEF,
    parameter logic [15:0] PROG_LO = ASD_PROG_LO_DEF
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire asd_req_t    shared_address_bus,
    output logic [15:0]      shared_data_bus,
    output logic             rd_valid,
    output logic             align_err,
    output logic             vec_access,
    output asd_region_t      region,
    output asd_tgt_t         sfb_req,
    output asd_tgt_t         p8_req,
    output asd_tgt_t         p16_req,
    output asd_tgt_t         ram_req,
    output asd_tgt_t         prog_req,
    input  wire logic [7:0]  sfb_rdata,
    input  wire logic [7:0]  p8_rdata,
    input  wire logic [15:0] p16_rdata,
    input  wire logic [15:0] ram_rdata,
    input  wire logic [15:0] prog_rdata
);

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    logic [15:0] a;
    logic        odd;
    logic        bad;
    logic [1:0]  be;
    logic [15:0] wd;
    asd_region_t reg_next;

    assign a   = shared_address_bus.addr;
    assign odd = a[0];

    // RAM end and program start are per-device parameters; anything
    // between them decodes to no region and is answered with zero
    // One region per address, priority free since windows do not overlap
    always_comb begin
        if (a <= ASD_SFB_HI) begin
            reg_next = ASD_REG_SFB;
        end else if (a >= ASD_P8_LO && a <= ASD_P8_HI) begin
            reg_next = ASD_REG_P8;
        end else if (a >= ASD_P16_LO && a <= ASD_P16_HI) begin
            reg_next = ASD_REG_P16;
        end else if (a >= ASD_RAM_LO && a <= RAM_HI) begin
            reg_next = ASD_REG_RAM;
        end else if (a >= PROG_LO) begin
            reg_next = ASD_REG_PROG;
        end else begin
            reg_next = ASD_REG_NONE;
        end
    end

    // Misaligned word or fetch is blocked, not split into two accesses;
    // splitting would need a second bus cycle the CPU never waits for
    assign bad = shared_address_bus.en & odd &
                 (~shared_address_bus.byte_acc |
                  shared_address_bus.fetch);

    // Byte data goes out on both lanes so a target needs no shifter;
    // the lane enable alone picks the byte that lands
    // Byte lanes: low byte at even address, high byte at the odd one
    always_comb begin
        if (shared_address_bus.byte_acc && !shared_address_bus.fetch) begin
            be = odd ? 2'b10 : 2'b01;
            wd = {shared_address_bus.wdata[7:0],
                  shared_address_bus.wdata[7:0]};
        end else begin
            be = 2'b11;
            wd = shared_address_bus.wdata;
        end
    end

    // ----------------------------------------------------------------
    // Target strobes, combinational handshake; one select at a time
    // ----------------------------------------------------------------
    // A refused access strobes no target, so a misaligned write can
    // never disturb the neighbouring byte or word
    logic go;
    assign go = shared_address_bus.en & ~bad;

    // Byte-wide targets: the word's high byte is simply dropped
    always_comb begin
        sfb_req       = '0;
        p8_req        = '0;
        p16_req       = '0;
        ram_req       = '0;
        prog_req      = '0;
        sfb_req.en    = go & (reg_next == ASD_REG_SFB);
        sfb_req.wr    = shared_address_bus.wr;
        sfb_req.be    = 2'b01;
        sfb_req.addr  = a;
        sfb_req.wdata = {8'h00, odd ? wd[15:8] : wd[7:0]};
        p8_req.en     = go & (reg_next == ASD_REG_P8);
        p8_req.wr     = shared_address_bus.wr;
        p8_req.be     = 2'b01;
        p8_req.addr   = a;
        p8_req.wdata  = {8'h00, odd ? wd[15:8] : wd[7:0]};
        p16_req.en    = go & (reg_next == ASD_REG_P16);
        p16_req.wr    = shared_address_bus.wr;
        p16_req.be    = be;
        p16_req.addr  = {a[15:1], 1'b0};
        p16_req.wdata = wd;
        ram_req.en    = go & (reg_next == ASD_REG_RAM);
        ram_req.wr    = shared_address_bus.wr;
        ram_req.be    = be;
        ram_req.addr  = {a[15:1], 1'b0};
        ram_req.wdata = wd;
        // Program memory is read-only from the bus; fetch and data alike
        // Its write path, if the device has one, sits outside this bridge
        prog_req.en   = go & (reg_next == ASD_REG_PROG) &
                        ~shared_address_bus.wr;
        prog_req.wr   = 1'b0;
        prog_req.be   = be;
        prog_req.addr = {a[15:1], 1'b0};
    end

    // ----------------------------------------------------------------
    // Read return, registered two cycles after the request
    // ----------------------------------------------------------------
    asd_region_t reg_reg;
    logic        rd_reg;
    logic        byte_reg;
    logic        odd_reg;
    logic        bad_reg;
    logic        vec_reg;
    logic [15:0] data_next;

    // Targets answer one cycle after their strobe, so the attributes of
    // the access wait here for that data to arrive
    // Capture access attributes for the return phase
    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_reg  <= ASD_REG_NONE;
            rd_reg   <= 1'b0;
            byte_reg <= 1'b0;
            odd_reg  <= 1'b0;
            bad_reg  <= 1'b0;
            vec_reg  <= 1'b0;
        end else begin
            reg_reg  <= reg_next;
            rd_reg   <= shared_address_bus.en & ~shared_address_bus.wr;
            byte_reg <= shared_address_bus.byte_acc &
                        ~shared_address_bus.fetch;
            odd_reg  <= odd;
            bad_reg  <= bad;
            vec_reg  <= go & (reg_next == ASD_REG_PROG) &
                        (a >= ASD_VEC_LO);
        end
    end

    // Steer the target's read data onto the shared data bus
    always_comb begin
        data_next = ASD_RD_RST;
        case (reg_reg)
            ASD_REG_SFB:  data_next = {8'h00, sfb_rdata};
            ASD_REG_P8:   data_next = {8'h00, p8_rdata};
            ASD_REG_P16:  data_next = byte_reg ?
                              {8'h00, p16_rdata[7:0]} : p16_rdata;
            ASD_REG_RAM:  data_next = ram_rdata;
            ASD_REG_PROG: data_next = prog_rdata;
            ASD_REG_NONE: data_next = ASD_RD_RST;
            default:      data_next = ASD_RD_RST;
        endcase
        // Odd RAM and program byte reads move the high lane down, upper byte cleared
        if (byte_reg && (reg_reg == ASD_REG_RAM ||
                         reg_reg == ASD_REG_PROG)) begin
            data_next = odd_reg ? {8'h00, data_next[15:8]} :
                                  {8'h00, data_next[7:0]};
        end
        if (bad_reg) begin
            data_next = ASD_RD_RST;
        end
    end

    // Writes and idle cycles put zero on the data bus, so a stale read
    // value never lingers where a later read could pick it up
    // Read data and status outputs come from flip-flops
    always_ff @(posedge mclk) begin
        if (rst) begin
            shared_data_bus <= ASD_RD_RST;
            rd_valid        <= 1'b0;
            align_err       <= 1'b0;
            vec_access      <= 1'b0;
            region          <= ASD_REG_NONE;
        end else begin
            shared_data_bus <= rd_reg ? data_next : ASD_RD_RST;
            rd_valid        <= rd_reg;
            align_err       <= bad_reg;
            vec_access      <= vec_reg;
            region          <= reg_reg;
        end
    end

endmodule

//--- hw/asd_pkg.sv
// Package with address map, access types and bus carriers for the bridge
package asd_pkg;

    // --------------------------------------------------------------
    // Address map
    // --------------------------------------------------------------
    localparam logic [15:0] ASD_SFB_LO      = 16'h0000;
    localparam logic [15:0] ASD_SFB_HI      = 16'h000f;
    localparam logic [15:0] ASD_P8_LO       = 16'h0010;
    localparam logic [15:0] ASD_P8_HI       = 16'h00ff;
    localparam logic [15:0] ASD_P16_LO      = 16'h0100;
    localparam logic [15:0] ASD_P16_HI      = 16'h01ff;
    localparam logic [15:0] ASD_RAM_LO      = 16'h0200;
    localparam logic [15:0] ASD_RAM_HI_DEF  = 16'h09ff;
    localparam logic [15:0] ASD_PROG_LO_DEF = 16'hf000;
    localparam logic [15:0] ASD_PROG_HI     = 16'hffff;
    localparam logic [15:0] ASD_VEC_LO      = 16'hffe0;
    localparam logic [15:0] ASD_VEC_TOP     = 16'hfffe;

    // --------------------------------------------------------------
    // Reset values
    // --------------------------------------------------------------
    localparam logic [15:0] ASD_RD_RST      = 16'h0000;

    // One-hot region codes; exactly one bit set per cycle
    typedef enum logic [5:0] {
        ASD_REG_NONE = 6'h01,
        ASD_REG_SFB  = 6'h02,
        ASD_REG_P8   = 6'h04,
        ASD_REG_P16  = 6'h08,
        ASD_REG_RAM  = 6'h10,
        ASD_REG_PROG = 6'h20
    } asd_region_t;

    // CPU request on the shared buses
    typedef struct packed {
        logic        en;
        logic        wr;
        logic        byte_acc;
        logic        fetch;
        logic [15:0] addr;
        logic [15:0] wdata;
    } asd_req_t;

    // Request forwarded to one target
    typedef struct packed {
        logic        en;
        logic        wr;
        logic [1:0]  be;
        logic [15:0] addr;
        logic [15:0] wdata;
    } asd_tgt_t;

endpackage

//--- verif/asd_chk.sv
// Assertion checker for the address space bridge
`timescale 1ns/1ps
module asd_chk
    import asd_pkg::*;
#(
    parameter logic [15:0] RAM_HI  = ASD_RAM_HI_DEF,
    parameter logic [15:0] PROG_LO = ASD_PROG_LO_DEF
) (
    input wire logic        mclk,
    input wire logic        rst,
    input wire asd_req_t    shared_address_bus,
    input wire logic [15:0] shared_data_bus,
    input wire logic        align_err,
    input wire logic        vec_access,
    input wire asd_region_t region,
    input wire asd_tgt_t    p8_req,
    input wire asd_tgt_t    ram_req,
    input wire asd_tgt_t    prog_req
);
    asd_req_t q;
    logic     bad;
    // Odd word or fetch must be refused
    assign q   = shared_address_bus;
    assign bad = q.en && q.addr[0] && (!q.byte_acc || q.fetch);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    one_region_a: assert property ($onehot(region))
        else $error("region select not one-hot");
    odd_word_a: assert property (bad |-> ##2 align_err
        && shared_data_bus == 16'h0000) else $error("odd word not refused");
    p8_low_a: assert property (p8_req.en && q.wr |-> p8_req.be == 2'h1
        && p8_req.wdata[7:0] == q.wdata[7:0]) else $error("p8 write lanes");
    prog_ro_a: assert property (q.en && q.wr |-> !prog_req.en
        && !prog_req.wr) else $error("program memory written");
    vec_hit_a: assert property (q.en && !bad && q.addr >= ASD_VEC_LO
        |-> ##2 vec_access) else $error("vector access missed");
    ram_route_a: assert property (q.en && !bad && q.addr >= ASD_RAM_LO
        && q.addr <= RAM_HI |-> ram_req.en && !ram_req.addr[0])
        else $error("ram not selected");
    gap_zero_a: assert property (q.en && q.addr > RAM_HI
        && q.addr < PROG_LO
        |-> ##2 region == ASD_REG_NONE && shared_data_bus == 16'h0000)
        else $error("gap access not empty");
    p16_zext_a: assert property (q.en && !q.wr && q.byte_acc
        && q.addr[15:8] == 8'h01 |-> ##2 shared_data_bus[15:8] == 8'h00)
        else $error("p16 byte read upper byte set");
endmodule

bind asd_bridge asd_chk #(.RAM_HI(RAM_HI), .PROG_LO(PROG_LO)) asd_chk_inst (
    .mclk(mclk), .rst(rst), .shared_address_bus(shared_address_bus),
    .shared_data_bus(shared_data_bus), .align_err(align_err),
    .vec_access(vec_access), .region(region), .p8_req(p8_req),
    .ram_req(ram_req), .prog_req(prog_req));

//--- verif/asd_tgt_model.sv
// Target-side model: pattern data one cycle after each strobe
`timescale 1ns/1ps
module asd_tgt_model
    import asd_pkg::*;
(
    input  wire logic     mclk,
    input  wire asd_tgt_t sfb_req,
    input  wire asd_tgt_t p8_req,
    input  wire asd_tgt_t p16_req,
    input  wire asd_tgt_t ram_req,
    input  wire asd_tgt_t prog_req,
    output logic [7:0]    sfb_rdata,
    output logic [7:0]    p8_rdata,
    output logic [15:0]   p16_rdata,
    output logic [15:0]   ram_rdata,
    output logic [15:0]   prog_rdata
);
    // Idle targets invert their data so a stale value never passes
    always_ff @(posedge mclk) begin
        sfb_rdata  <= sfb_req.en ? sfb_req.addr[7:0] ^ 8'h3c : ~sfb_rdata;
        p8_rdata   <= p8_req.en ? p8_req.addr[7:0] ^ 8'h3c : ~p8_rdata;
        p16_rdata  <= p16_req.en ? p16_req.addr ^ 16'h5a3c : ~p16_rdata;
        ram_rdata  <= ram_req.en ? ram_req.addr ^ 16'h5a3c : ~ram_rdata;
        prog_rdata <= prog_req.en ? prog_req.addr ^ 16'h5a3c : ~prog_rdata;
    end
endmodule

//--- verif/test_asd_bridge.sv
// Self-checking testbench for the address space bridge
`timescale 1ns/1ps
module test_asd_bridge;
    import asd_pkg::*;
    localparam logic [15:0] RAM_HI  = 16'h05ff;
    localparam logic [15:0] PROG_LO = 16'he000;
    logic        mclk = 1'b0;
    logic        rst  = 1'b1;
    asd_req_t    req  = '0;
    asd_req_t    old;
    asd_req_t    hist[$];
    logic [15:0] rdat, prd, rrd, p16rd, a, lf = 16'h0025;
    logic [7:0]  srd, p8rd;
    logic        rv, ae, va, by;
    asd_region_t rg;
    asd_tgt_t    sfb, p8, p16, ram, prog;
    int          num_errors = 0, tests_run = 0, cycles = 0;

    asd_bridge #(.RAM_HI(RAM_HI), .PROG_LO(PROG_LO)) asd_bridge_inst (
        .mclk(mclk), .rst(rst), .shared_address_bus(req),
        .shared_data_bus(rdat), .rd_valid(rv), .align_err(ae),
        .vec_access(va), .region(rg), .sfb_req(sfb), .p8_req(p8),
        .p16_req(p16), .ram_req(ram), .prog_req(prog), .sfb_rdata(srd),
        .p8_rdata(p8rd), .p16_rdata(p16rd), .ram_rdata(rrd),
        .prog_rdata(prd));
    asd_tgt_model asd_tgt_model_inst (
        .mclk(mclk), .sfb_req(sfb), .p8_req(p8), .p16_req(p16),
        .ram_req(ram), .prog_req(prog), .sfb_rdata(srd), .p8_rdata(p8rd),
        .p16_rdata(p16rd), .ram_rdata(rrd), .prog_rdata(prd));

    // ----
    // Expectation functions
    // ----
    function automatic logic [15:0] step(logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic asd_region_t reg_of(logic [15:0] x);
        if (x <= ASD_SFB_HI) return ASD_REG_SFB;
        if (x <= ASD_P8_HI) return ASD_REG_P8;
        if (x <= ASD_P16_HI) return ASD_REG_P16;
        if (x <= RAM_HI) return ASD_REG_RAM;
        if (x >= PROG_LO) return ASD_REG_PROG;
        return ASD_REG_NONE;
    endfunction
    // Words and fetches must sit at even addresses; bytes may be anywhere
    function automatic logic ok_of(asd_req_t r);
        return !r.addr[0] || (r.byte_acc && !r.fetch);
    endfunction
    // Narrow targets see the byte address, wide ones the word address
    function automatic logic [15:0] dat_of(asd_req_t r);
        logic [15:0] w;
        logic        nar;
        nar = reg_of(r.addr) inside {ASD_REG_SFB, ASD_REG_P8};
        w = (nar ? r.addr : {r.addr[15:1], 1'b0}) ^ 16'h5a3c;
        if (!r.en || r.wr || !ok_of(r)) return 16'h0000;
        if (reg_of(r.addr) == ASD_REG_NONE) return 16'h0000;
        if (nar || (r.byte_acc && !r.addr[0])) return {8'h00, w[7:0]};
        return r.byte_acc ? {8'h00, w[15:8]} : w;
    endfunction
    function automatic asd_req_t mk(logic [15:0] x, logic [2:0] k);
        return '{1'b1, k[2], k[1], k[0], x, {lf[7:0], lf[15:8]}};
    endfunction

    task automatic check(logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic send(asd_req_t r);
        @(posedge mclk);
        req <= r;
    endtask
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    always #12.5 mclk = ~mclk;

    // Outputs answer the request applied two rising edges earlier
    always @(negedge mclk) begin
        if (req.en && req.wr && ok_of(req)) begin
            if (reg_of(req.addr) == ASD_REG_P8)
                check({p8.be, p8.wdata[7:0]}, {2'h1, req.wdata[7:0]});
            if (reg_of(req.addr) == ASD_REG_RAM)
                check({ram.en, ram.be, ram.wdata}, {1'b1,
                    req.byte_acc ? {req.addr[0], !req.addr[0]} : 2'h3,
                    req.byte_acc ? {2{req.wdata[7:0]}} : req.wdata});
        end
        if (req.en && req.wr)
            check(prog.en, 1'b0);
        if (req.en && !ok_of(req))
            check({sfb.en, p8.en, p16.en, ram.en, prog.en}, 5'h0);
        hist.push_back(req);
        if (hist.size() > 2) begin
            old = hist.pop_front();
            check(rdat, dat_of(old));
            check(rv, old.en && !old.wr);
            check(ae, old.en && !ok_of(old));
            if (old.en && ok_of(old))
                check({va, rg}, {old.addr >= ASD_VEC_LO,
                    reg_of(old.addr)});
        end
    end

    // Cut a hang short
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            test_done();
        end
    end

    initial begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        send(mk(16'hfffe, 3'h1));
        send(mk(16'h0100, 3'h2));
        send(mk(16'h0010, 3'h4));
        send(mk(16'h00fe, 3'h0));
        send(mk(16'h0203, 3'h0));
        send(mk(16'h0600, 3'h2));
        send(mk(16'he000, 3'h4));
        send(mk(16'h05ff, 3'h2));
        $display("corner cases done");
        for (int i = 0; i < 1200; i++) begin
            lf = step(lf);
            a = lf;
            case (lf[2:0])
                3'h0: a = {12'h000, lf[7:4]};
                3'h1: a = {8'h00, lf[11:4]};
                3'h2: a = {8'h01, lf[11:4]};
                3'h3: a = ASD_RAM_LO + {6'h00, lf[12:3]};
                default: ;
            endcase
            by = lf[4] || a <= ASD_SFB_HI;
            if (a[15:8] == 8'h01 && by) a[0] = 1'b0;
            if (!by && lf[9:8] != 2'h0) a[0] = 1'b0;
            send(mk(a, {lf[5], by, !lf[5] && !by && lf[6]}));
        end
        $display("random traffic done");
        // Mid-run reset: outputs clear, then the bridge answers again
        send('0);
        repeat (3) @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        check({rv, ae, va, rdat, rg}, {3'h0, ASD_RD_RST, ASD_REG_NONE});
        @(posedge mclk);
        rst <= 1'b0;
        send(mk(16'h0204, 3'h0));
        send('0);
        repeat (4) @(posedge mclk);
        $display("reset test done");
        test_done();
    end
endmodule
